// ==== common/bei_pkg.sv ====
// constants for the buffer event interrupt enable block
//------------------------------------------------------------------
//------------------------------------------------------------------
package bei_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BUS_W  = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned ID_W   = 6;
    localparam int unsigned CNT_W  = 10;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_ENABLES = 10'h10a;
    localparam logic [9:0] IDX_EVENTS  = 10'h12c;
    localparam logic [9:0] IDX_LOST    = 10'h130;
    localparam logic [9:0] IDX_COLL    = 10'h132;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = {IDX_ENABLES, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_EVENTS  = {IDX_EVENTS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LOST    = {IDX_LOST, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_COLL    = {IDX_COLL, 2'h0};

    localparam logic [ID_W-1:0] ID_ENABLES = 6'h0b;
    localparam logic [ID_W-1:0] ID_EVENTS  = 6'h0c;
    localparam logic [ID_W-1:0] ID_LOST    = 6'h10;
    localparam logic [ID_W-1:0] ID_COLL    = 6'h12;

    localparam int unsigned BIT_SOFT  = 6;
    localparam int unsigned BIT_DMA   = 7;
    localparam int unsigned BIT_TXSP  = 8;
    localparam int unsigned BIT_STARV = 9;
    localparam int unsigned BIT_LOST  = 10;
    localparam int unsigned BIT_EARLY = 11;
    localparam int unsigned BIT_COLLH = 12;
    localparam int unsigned BIT_LOSTH = 13;
    localparam int unsigned BIT_MATCH = 15;

    localparam logic [DATA_W-1:0] ENABLES_RESET = 16'h000b;
    localparam logic [DATA_W-1:0] ENABLE_MASK   = 16'hbf80;
    localparam logic [DATA_W-1:0] EVENT_MASK    = 16'h8fc0;
    localparam logic [DATA_W-1:0] SOFT_MASK     = 16'h0040;
    localparam logic [CNT_W-1:0]  CNT_HALF_FROM = 10'h1ff;
endpackage : bei_pkg

// ==== rtl/bei_counter.sv ====
// ten-bit clear-on-read event counter with half-way crossing pulse
`timescale 1ns/1ps
module bei_counter #(
    parameter int unsigned W = bei_pkg::CNT_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         inc,
    input  wire logic         clr,
    output logic [W-1:0]      count,
    output logic              half_cross
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    //------------------------------------------------------------
    // count
    //------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = '0;
        end
        if (inc) begin
            // increment after clear so a same-cycle event survives
            count_nxt = clr ? W'(1) : W'(count_r + W'(1));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count      = count_r;
    // one pulse per crossing only
    assign half_cross = inc && !clr &&
                        (count_r == W'(bei_pkg::CNT_HALF_FROM));
endmodule : bei_counter

// ==== rtl/bei_top.sv ====
// buffer event flags, interrupt enables and miss/collision counters
`timescale 1ns/1ps
module bei_top #(
    parameter int unsigned ADDR_W = bei_pkg::ADDR_W,
    parameter int unsigned BUS_W  = bei_pkg::BUS_W,
    parameter int unsigned CNT_W  = bei_pkg::CNT_W
) (
    input  wire logic               clk,
    input  wire logic               rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [BUS_W-1:0]   avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [BUS_W-1:0]        avs_readdata,
    output logic                    avs_waitrequest,
    // configuration memory image
    input  wire logic               cfg_mem_present,
    input  wire logic [15:0]        cfg_mem_value,
    // buffer events from the datapath
    input  wire logic               rx_dma_done,
    input  wire logic               tx_space_ready,
    input  wire logic               tx_data_starved,
    input  wire logic               rx_frame_lost,
    input  wire logic               early_receive_hit,
    input  wire logic               address_match_hit,
    // collision sources
    input  wire logic               tp_rx_active,
    input  wire logic               collision_input_active,
    input  wire logic               transmitting,
    // results
    output logic                    irq,
    output logic                    tx_abandon
);
    localparam int unsigned DW = bei_pkg::DATA_W;
    localparam int unsigned IW = bei_pkg::ID_W;

    //------------------------------------------------------------
    // declarations
    //------------------------------------------------------------
    logic              wait_r;
    logic              wait_nxt;
    logic [BUS_W-1:0]  rdata_r;
    logic [BUS_W-1:0]  rdata_nxt;
    logic              load_done_r;
    logic              load_done_nxt;
    logic [DW-1:0]     enables_r;
    logic [DW-1:0]     enables_nxt;
    logic [DW-1:0]     flags_r;
    logic [DW-1:0]     flags_nxt;
    logic              coll_half_r;
    logic              coll_half_nxt;
    logic              lost_half_r;
    logic              lost_half_nxt;
    logic              coll_prev_r;
    logic              coll_prev_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic              abandon_r;
    logic              abandon_nxt;

    logic              take;
    logic              hit_enables;
    logic              hit_events;
    logic              hit_lost;
    logic              hit_coll;
    logic              wr_enables;
    logic              rd_events;
    logic              rd_lost;
    logic              rd_coll;
    logic              soft_req;
    logic              coll_now;
    logic              coll_inc;
    logic [DW-1:0]     set_mask;
    logic [DW-1:0]     pending;
    logic [CNT_W-1:0]  lost_count;
    logic [CNT_W-1:0]  coll_count;
    logic              lost_cross;
    logic              coll_cross;

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // counter register image: count above the identifier
    function automatic logic [BUS_W-1:0] cnt_word(
        input logic [CNT_W-1:0] cnt,
        input logic [IW-1:0]    id
    );
        cnt_word = BUS_W'({cnt, id});
    endfunction : cnt_word

    //------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------
    always_comb begin
        // requests wait until the strap load has finished
        take = (avs_read || avs_write) && wait_r && load_done_r;
        hit_enables = (avs_address == bei_pkg::ADDR_ENABLES);
        hit_events  = (avs_address == bei_pkg::ADDR_EVENTS);
        hit_lost    = (avs_address == bei_pkg::ADDR_LOST);
        hit_coll    = (avs_address == bei_pkg::ADDR_COLL);
        // full low half-word with matching identifier only
        wr_enables  = take && avs_write && hit_enables &&
                      (&avs_byteenable[1:0]) &&
                      (avs_writedata[IW-1:0] ==
                       bei_pkg::ID_ENABLES);
        rd_events   = take && avs_read && hit_events;
        rd_lost     = take && avs_read && hit_lost;
        rd_coll     = take && avs_read && hit_coll;
    end

    //------------------------------------------------------------
    // bus answer
    //------------------------------------------------------------
    always_comb begin
        wait_nxt  = !take;
        rdata_nxt = rdata_r;
        if (take && avs_read) begin
            rdata_nxt = '0;
            if (hit_enables) begin
                rdata_nxt = BUS_W'(enables_r);
            end else if (hit_events) begin
                rdata_nxt = BUS_W'(flags_r) |
                            BUS_W'(bei_pkg::ID_EVENTS);
            end else if (hit_lost) begin
                rdata_nxt = cnt_word(lost_count, bei_pkg::ID_LOST);
            end else if (hit_coll) begin
                rdata_nxt = cnt_word(coll_count, bei_pkg::ID_COLL);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    //------------------------------------------------------------
    // enable register
    //------------------------------------------------------------
    always_comb begin
        load_done_nxt = 1'b1;
        enables_nxt   = enables_r;
        soft_req      = 1'b0;
        if (!load_done_r) begin
            // strap caught at the first edge after reset release
            if (cfg_mem_present) begin
                enables_nxt = (cfg_mem_value & bei_pkg::ENABLE_MASK) |
                              DW'(bei_pkg::ID_ENABLES);
            end
        end else if (wr_enables) begin
            enables_nxt = (avs_writedata[DW-1:0] &
                           bei_pkg::ENABLE_MASK) |
                          DW'(bei_pkg::ID_ENABLES);
            // act-once request, never stored
            soft_req = avs_writedata[bei_pkg::BIT_SOFT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_done_r <= 1'b0;
            enables_r   <= bei_pkg::ENABLES_RESET;
        end else begin
            load_done_r <= load_done_nxt;
            enables_r   <= enables_nxt;
        end
    end

    //------------------------------------------------------------
    // collision sensing
    //------------------------------------------------------------
    always_comb begin
        coll_now = (tp_rx_active || collision_input_active) &&
                   transmitting;
        coll_prev_nxt = coll_now;
        coll_inc = coll_now && !coll_prev_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coll_prev_r <= 1'b0;
        end else begin
            coll_prev_r <= coll_prev_nxt;
        end
    end

    //------------------------------------------------------------
    // counters
    //------------------------------------------------------------
    bei_counter #(
        .W          (CNT_W)
    ) u_lost (
        .clk        (clk),
        .rst        (rst),
        .inc        (rx_frame_lost),
        .clr        (rd_lost),
        .count      (lost_count),
        .half_cross (lost_cross)
    );

    bei_counter #(
        .W          (CNT_W)
    ) u_coll (
        .clk        (clk),
        .rst        (rst),
        .inc        (coll_inc),
        .clr        (rd_coll),
        .count      (coll_count),
        .half_cross (coll_cross)
    );

    //------------------------------------------------------------
    // event flags
    //------------------------------------------------------------
    always_comb begin
        set_mask = '0;
        set_mask[bei_pkg::BIT_SOFT]  = soft_req;
        set_mask[bei_pkg::BIT_DMA]   = rx_dma_done;
        set_mask[bei_pkg::BIT_TXSP]  = tx_space_ready;
        set_mask[bei_pkg::BIT_STARV] = tx_data_starved;
        set_mask[bei_pkg::BIT_LOST]  = rx_frame_lost;
        set_mask[bei_pkg::BIT_EARLY] = early_receive_hit;
        // match precedes the early hit in the receive sequence
        set_mask[bei_pkg::BIT_MATCH] = address_match_hit;
        // set wins over the clear-on-read
        flags_nxt = flags_r;
        if (rd_events) begin
            flags_nxt = '0;
        end
        flags_nxt = (flags_nxt | set_mask) & bei_pkg::EVENT_MASK;
        coll_half_nxt = (coll_half_r && !rd_coll) || coll_cross;
        lost_half_nxt = (lost_half_r && !rd_lost) || lost_cross;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r     <= '0;
            coll_half_r <= 1'b0;
            lost_half_r <= 1'b0;
        end else begin
            flags_r     <= flags_nxt;
            coll_half_r <= coll_half_nxt;
            lost_half_r <= lost_half_nxt;
        end
    end

    //------------------------------------------------------------
    // interrupt and abandon outputs
    //------------------------------------------------------------
    always_comb begin
        // soft flag always counts; others need their enable
        pending = flags_r & (enables_r | bei_pkg::SOFT_MASK);
        irq_nxt = (|pending) ||
                  (coll_half_r &&
                   enables_r[bei_pkg::BIT_COLLH]) ||
                  (lost_half_r &&
                   enables_r[bei_pkg::BIT_LOSTH]);
        // frame dropped without retry on starvation
        abandon_nxt = tx_data_starved;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r     <= 1'b0;
            abandon_r <= 1'b0;
        end else begin
            irq_r     <= irq_nxt;
            abandon_r <= abandon_nxt;
        end
    end

    //------------------------------------------------------------
    // port drive
    //------------------------------------------------------------
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq             = irq_r;
    assign tx_abandon      = abandon_r;
endmodule : bei_top

// ==== tb/bei_props.sv ====
// concurrent checks on the buffer event block ports
`timescale 1ns/1ps
module bei_props #(
    parameter int unsigned ADDR_W = bei_pkg::ADDR_W,
    parameter int unsigned BUS_W  = bei_pkg::BUS_W
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [BUS_W-1:0]  avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [BUS_W-1:0]  avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              cfg_mem_present,
    input wire logic [15:0]       cfg_mem_value,
    input wire logic              rx_dma_done,
    input wire logic              tx_data_starved,
    input wire logic              address_match_hit,
    input wire logic              irq,
    input wire logic              tx_abandon
);
    //------------------------------------------------------------
    // shadow of the enables
    //------------------------------------------------------------
    logic [15:0] en_r;
    logic [15:0] en_nxt;
    logic        strap_r;
    logic        wr_ok;
    assign wr_ok = avs_write && avs_waitrequest && !strap_r
        && avs_address == bei_pkg::ADDR_ENABLES
        && avs_writedata[5:0] == bei_pkg::ID_ENABLES
        && avs_byteenable[1:0] == 2'h3;
    always_comb begin
        en_nxt = en_r;
        if (strap_r && cfg_mem_present)
            en_nxt = cfg_mem_value & bei_pkg::ENABLE_MASK;
        else if (wr_ok)
            en_nxt = avs_writedata[15:0] & bei_pkg::ENABLE_MASK;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_r    <= 16'h0000;
            strap_r <= 1'h1;
        end else begin
            en_r    <= en_nxt;
            strap_r <= 1'h0;
        end
    end
    //------------------------------------------------------------
    // properties
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest && !strap_r;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_read_of(a);
        avs_read && avs_waitrequest && !strap_r && avs_address == a;
    endsequence
    property p_id(a, id);
        s_read_of(a) |=> avs_readdata[5:0] == id
            && avs_readdata[31:16] == 16'h0000;
    endproperty
    AST_ANSWER_ONE: assert property (s_taken |=> s_answer)
        else $error("bus answer not exactly one cycle");
    AST_SOFT_IRQ: assert property (wr_ok && avs_writedata[6] |-> ##2 irq)
        else $error("soft request gave no interrupt");
    AST_DMA_IRQ: assert property (rx_dma_done && en_r[7] |-> ##2 irq)
        else $error("dma done gave no interrupt");
    AST_STARVE_IRQ: assert property (tx_data_starved && en_r[9] |-> ##2 irq)
        else $error("underrun gave no interrupt");
    AST_MATCH_IRQ: assert property (address_match_hit && en_r[15] |-> ##2 irq)
        else $error("address match gave no interrupt");
    AST_ABANDON: assert property (tx_data_starved |=> tx_abandon ##1 !tx_abandon)
        else $error("abandon pulse missing");
    AST_MASKED: assert property (!irq && (en_r & bei_pkg::ENABLE_MASK) == 16'h0000
        && !avs_write |=> !irq)
        else $error("interrupt with all enables clear");
    AST_EVT_ID: assert property (p_id(bei_pkg::ADDR_EVENTS, bei_pkg::ID_EVENTS))
        else $error("event register identifier wrong");
    AST_LOST_ID: assert property (p_id(bei_pkg::ADDR_LOST, bei_pkg::ID_LOST))
        else $error("lost counter identifier wrong");
    AST_COLL_ID: assert property (p_id(bei_pkg::ADDR_COLL, bei_pkg::ID_COLL))
        else $error("collision counter identifier wrong");
endmodule : bei_props

bind bei_top bei_props #(.ADDR_W(ADDR_W), .BUS_W(BUS_W)) i_props (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cfg_mem_present(cfg_mem_present), .cfg_mem_value(cfg_mem_value),
    .rx_dma_done(rx_dma_done), .tx_data_starved(tx_data_starved),
    .address_match_hit(address_match_hit), .irq(irq),
    .tx_abandon(tx_abandon)
);

// ==== tb/bei_host.sv ====
// host software model speaking avalon-mm to the register block
`timescale 1ns/1ps
module bei_host (
    input  wire logic        clk,
    output logic [11:0]      avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 12'h000;
        avs_read       = 1'h0;
        avs_write      = 1'h0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end
    task automatic access(input logic rd, input logic [11:0] a,
        input logic [15:0] d, input logic [3:0] be,
        output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_read       <= rd;
        avs_write      <= !rd;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        // no timeout here; a wait ends when waitrequest drops, or at the bench timeout
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_read      <= 1'h0;
        avs_write     <= 1'h0;
        avs_writedata <= ~{16'h0000, d};
    endtask : access
    // early enable bit 11 taken from d like the other enable bits
    task automatic wr_en(input logic [15:0] d);
        logic [31:0] q;
        access(1'h0, bei_pkg::ADDR_ENABLES, {d[15:6], bei_pkg::ID_ENABLES},
            4'hf, q);
    endtask : wr_en
endmodule : bei_host

// ==== tb/tb_buffer_event_interrupt_enables.sv ====
// self-checking bench for the buffer event interrupt block
`timescale 1ns/1ps
module tb_buffer_event_interrupt_enables;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  ev = 6'h00;
    logic        tp = 1'h0;
    logic        ci = 1'h0;
    logic        tx = 1'h0;
    logic        irq;
    logic        abandon;
    logic        cfg_p = 1'h0;
    logic [15:0] cfg_v = 16'h0000;
    int          n_abandon = 0;
    logic [31:0] q;
    int          err_total = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          i;
    logic [15:0] evb [6] = '{16'h0080, 16'h0100, 16'h0200, 16'h0400,
                             16'h0800, 16'h8000};
    bei_top i_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cfg_mem_present(cfg_p), .cfg_mem_value(cfg_v),
        .rx_dma_done(ev[0]), .tx_space_ready(ev[1]),
        .tx_data_starved(ev[2]), .rx_frame_lost(ev[3]),
        .early_receive_hit(ev[4]), .address_match_hit(ev[5]),
        .tp_rx_active(tp), .collision_input_active(ci),
        .transmitting(tx), .irq(irq), .tx_abandon(abandon)
    );
    bei_host i_host (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    always #4 clk = ~clk;
    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    task give_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task rd(input logic [11:0] a, input logic [31:0] exp, input string w);
        i_host.access(1'h1, a, 16'h0000, 4'hf, q);
        check(w, q, exp);
    endtask : rd
    task pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'h1;
        @(posedge clk);
        ev[k] <= 1'h0;
    endtask : pulse
    task irq_is(input logic e);
        repeat (3) @(posedge clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask : irq_is
    task tog(input logic sel);
        @(posedge clk);
        tp <= sel;
        ci <= !sel;
        @(posedge clk);
        tp <= 1'h0;
        ci <= 1'h0;
    endtask : tog
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_total++;
            give_verdict();
        end
    end
    // abandon pulses seen
    always @(posedge clk) begin
        if (abandon === 1'h1)
            n_abandon <= n_abandon + 1;
    end
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        rd(bei_pkg::ADDR_ENABLES, 32'h0000_000b, "enables");
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_000c, "events");
        rd(bei_pkg::ADDR_LOST, 32'h0000_0010, "lost");
        rd(bei_pkg::ADDR_COLL, 32'h0000_0012, "coll");
        rd(12'h000, 32'h0000_0000, "unmapped");
        i_host.access(1'h0, bei_pkg::ADDR_ENABLES, 16'h8f80, 4'hf, q);
        i_host.access(1'h0, bei_pkg::ADDR_ENABLES, 16'h8f8b, 4'h1, q);
        rd(bei_pkg::ADDR_ENABLES, 32'h0000_000b, "enables");
        i_host.wr_en(16'hffbf);
        rd(bei_pkg::ADDR_ENABLES, 32'h0000_bf8b, "enables");
        for (i = 0; i < 6; i++) begin
            pulse(i);
            irq_is(1'h1);
            rd(bei_pkg::ADDR_EVENTS, {16'h0, evb[i] | 16'h000c}, "events");
            irq_is(1'h0);
        end
        i_host.wr_en(16'h0000);
        for (i = 0; i < 6; i++)
            pulse(i);
        irq_is(1'h0);
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_8f8c, "events");
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_000c, "events");
        i_host.wr_en(16'h0040);
        irq_is(1'h1);
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_004c, "events");
        irq_is(1'h0);
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_000c, "events");
        rd(bei_pkg::ADDR_ENABLES, 32'h0000_000b, "enables");
        rd(bei_pkg::ADDR_LOST, 32'h0000_0090, "lost");
        i_host.wr_en(16'h2000);
        repeat (511) pulse(3);
        irq_is(1'h0);
        pulse(3);
        irq_is(1'h1);
        rd(bei_pkg::ADDR_LOST, 32'h0000_8010, "lost");
        irq_is(1'h0);
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_040c, "events");
        i_host.wr_en(16'h1000);
        repeat (3) tog(1'h1);
        @(posedge clk);
        tx <= 1'h1;
        repeat (256) tog(1'h1);
        repeat (255) tog(1'h0);
        irq_is(1'h0);
        tog(1'h0);
        irq_is(1'h1);
        rd(bei_pkg::ADDR_COLL, 32'h0000_8012, "coll");
        irq_is(1'h0);
        rd(bei_pkg::ADDR_COLL, 32'h0000_0012, "coll");
        check("abandon", n_abandon, 32'h0000_0002);
        // mid-run reset with a configuration memory image present
        pulse(0);
        @(posedge clk);
        cfg_p <= 1'h1;
        cfg_v <= 16'hffff;
        rst   <= 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        rd(bei_pkg::ADDR_ENABLES, 32'h0000_bf8b, "enables");
        rd(bei_pkg::ADDR_EVENTS, 32'h0000_000c, "events");
        irq_is(1'h0);
        give_verdict();
    end
endmodule : tb_buffer_event_interrupt_enables
